// [common/event_bank_pkg.sv]
// package for the host interrupt event bank: offsets, bit positions, carriers
package event_bank_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_SET   = 8'h80;
  localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h84;
  localparam logic [7:0] ADDR_EVENT_MASK  = 8'h88;
  localparam logic [7:0] ADDR_LINK_CTRL   = 8'h8c;
  localparam logic [7:0] ADDR_HC_CTRL     = 8'h90;
  localparam logic [7:0] ADDR_CYCLE_TIMER = 8'h94;

  // ---------------------------------------------------------------------------
  // event bit positions
  // ---------------------------------------------------------------------------
  localparam int BIT_RSVD31        = 31;
  localparam int BIT_EEPROM_DONE   = 30;
  localparam int BIT_SOFTWARE      = 29;
  localparam int BIT_RSVD28        = 28;
  localparam int BIT_TARDY_ACK     = 27;
  localparam int BIT_PHY_BYTE      = 26;
  localparam int BIT_OVERLONG      = 25;
  localparam int BIT_FATAL_HALT    = 24;
  localparam int BIT_MISMATCH      = 23;
  localparam int BIT_MISSED_CYCLE  = 22;
  localparam int EVENT_LO          = 22;
  localparam int EVENT_HI          = 31;
  localparam int NUM_EVENTS        = 10;

  localparam logic [31:0] EVENT_IMPL_MASK = 32'h6fc0_0000;
  localparam logic [31:0] EVENT_RESET     = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] HC_CTRL_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------------------
  localparam int BIT_CYCLE_ROOT    = 21;
  localparam int BIT_TARDY_ENABLE  = 0;
  localparam int SEC_HI            = 31;
  localparam int SEC_LO            = 25;
  localparam int CNT_HI            = 24;
  localparam int CNT_LO            = 12;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int OVERLONG_US       = 125;
  localparam int OVERLONG_CYCLES   = OVERLONG_US * CLK_MHZ;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       eeprom_done;
    logic       rx_fifo_pending;
    logic       phy_resp_busy;
    logic       ack_tardy_sent;
    logic       phy_byte_received;
    logic       cycle_start_tx;
    logic       subaction_gap_end;
    logic       context_halt;
    logic       cycle_start_rx;
    logic [6:0] rx_seconds;
    logic [12:0] rx_count;
    logic       arb_reset_gap;
  } event_src_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

endpackage : event_bank_pkg

// [hw/host_interrupt_event_bank.sv]
// host interrupt event bank with avalon-mm register slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/10ps

// Operation
// - rising source edge or set-write sets bit
// - only clear-port write of one clears
// - set port read returns raw events
// - clear port read returns events and mask
// - bits 31 and 28 read zero
// - eeprom read done raises bit 30
// - bit 29 software only
// - tardy enable gates three tardy causes
// - phy byte arrival sets bit 26
// - cycle root: over 125us sets bit 25
// - overlong cycle clears cycle root enable
// - subunit halt sets bit 24
// - halt blocks the tardy ack event (bit 27) only
// - cycle start field mismatch sets bit 23
// - no cycle start between syncs sets 22
// - predicted loss may set bit 22 early
// - count lsb toggle makes cycle sync
module host_interrupt_event_bank
  import event_bank_pkg::*;
#(
  parameter int OVERLONG_LIMIT = OVERLONG_CYCLES
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // avalon-mm slave
  input  wire event_bank_pkg::avmm_req_t   avm_req,
  output logic [31:0]                      avm_readdata,
  output logic                             avm_waitrequest,
  // event sources from the controller
  input  wire event_bank_pkg::event_src_t  src,
  // local cycle timer from the controller's timer
  input  wire logic [31:0]                 cycle_timer,
  // outputs
  output logic                             irq,
  output logic                             cycle_root_enable,
  output logic                             tardy_ack_enable,
  output logic                             cycle_sync_event
);
  import event_bank_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0] event_latch_register, event_latch_next;
  logic [31:0] event_mask_register,  event_mask_next;
  logic [31:0] link_ctrl_reg,        link_ctrl_next;
  logic [31:0] hc_ctrl_reg,          hc_ctrl_next;
  logic [31:0] rdata_reg,            rdata_next;
  logic        ack_reg,              ack_next;
  logic        wait_reg,             wait_next;
  logic        irq_reg,              irq_next;
  logic        sync_reg,             sync_next;
  event_src_t  src_q_reg;
  logic [31:0] hw_level;
  logic [31:0] hw_prev_reg;
  logic [31:0] hw_rise;
  logic        cnt_lsb_reg;
  logic        overlong_run_reg,     overlong_run_next;
  logic [31:0] overlong_cnt_reg,     overlong_cnt_next;
  logic        seen_start_reg,       seen_start_next;
  logic        first_gap_reg,        first_gap_next;
  logic        overlong_hit;
  logic        missed_hit;
  logic        mismatch_hit;
  logic        sync_pulse;

  // writes land on the edge that sees waitrequest low, reads are fetched one edge earlier
  wire logic   wr_en  = avm_req.write & ack_reg;
  wire logic   rd_en  = avm_req.read  & ~ack_reg;
  wire logic   wr_set = wr_en && avm_req.address == ADDR_EVENT_SET;
  wire logic   wr_clr = wr_en && avm_req.address == ADDR_EVENT_CLEAR;

  // ---------------------------------------------------------------------------
  // cycle sync and cycle supervision
  // ---------------------------------------------------------------------------
  assign sync_pulse   = cycle_timer[CNT_LO] != cnt_lsb_reg;
  assign mismatch_hit = src_q_reg.cycle_start_rx &&
                        ({src_q_reg.rx_seconds, src_q_reg.rx_count} !=
                         cycle_timer[SEC_HI:CNT_LO]);
  assign overlong_hit = overlong_run_reg && link_ctrl_reg[BIT_CYCLE_ROOT] &&
                        overlong_cnt_reg >= 32'(OVERLONG_LIMIT);
  // lost on sync without start, or predicted after first gap / arb reset gap
  assign missed_hit   = (sync_pulse && !seen_start_reg) ||
                        (!seen_start_reg && !first_gap_reg &&
                         src_q_reg.subaction_gap_end && !src_q_reg.cycle_start_rx) ||
                        (!seen_start_reg && src_q_reg.arb_reset_gap);

  always_comb begin
    overlong_run_next = overlong_run_reg;
    overlong_cnt_next = overlong_cnt_reg;
    seen_start_next   = seen_start_reg;
    first_gap_next    = first_gap_reg;
    if (src_q_reg.cycle_start_tx) begin
      overlong_run_next = 1'b1;
      overlong_cnt_next = 32'h0000_0000;
    end else if (overlong_run_reg) begin
      overlong_cnt_next = overlong_cnt_reg + 32'h0000_0001;
      if (src_q_reg.subaction_gap_end || overlong_hit) begin
        overlong_run_next = 1'b0;
      end
    end
    if (src_q_reg.subaction_gap_end) begin
      first_gap_next = 1'b1;
    end
    if (src_q_reg.cycle_start_tx || src_q_reg.cycle_start_rx) begin
      seen_start_next = 1'b1;
    end
    if (sync_pulse) begin
      seen_start_next = 1'b0;
      first_gap_next  = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // event levels and edge detection
  // ---------------------------------------------------------------------------
  always_comb begin
    hw_level                   = 32'h0000_0000;
    hw_level[BIT_EEPROM_DONE]  = src_q_reg.eeprom_done;
    hw_level[BIT_TARDY_ACK]    = hc_ctrl_reg[BIT_TARDY_ENABLE] &
                                 (src_q_reg.rx_fifo_pending | src_q_reg.phy_resp_busy |
                                  src_q_reg.ack_tardy_sent);
    hw_level[BIT_PHY_BYTE]     = src_q_reg.phy_byte_received;
    hw_level[BIT_OVERLONG]     = overlong_hit;
    hw_level[BIT_FATAL_HALT]   = src_q_reg.context_halt;
    hw_level[BIT_MISMATCH]     = mismatch_hit;
    hw_level[BIT_MISSED_CYCLE] = missed_hit;
  end

  // bit 29 has no hardware source, so its level stays zero
  assign hw_rise = hw_level & ~hw_prev_reg & EVENT_IMPL_MASK;

  // ---------------------------------------------------------------------------
  // event latch, mask and control registers
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] gated;
    gated = hw_rise;
    // halted contexts are the transfer sources; of their events only the tardy ack is held off
    if (event_latch_register[BIT_FATAL_HALT]) begin
      gated[BIT_TARDY_ACK] = 1'b0;
    end
    event_latch_next    = event_latch_register;
    event_mask_next     = event_mask_register;
    link_ctrl_next      = link_ctrl_reg;
    hc_ctrl_next        = hc_ctrl_reg;
    if (wr_clr) begin
      event_latch_next = event_latch_register & ~avm_req.writedata;
    end
    // set wins over a clear in the same cycle
    event_latch_next = (event_latch_next | gated |
                        (wr_set ? avm_req.writedata : 32'h0000_0000)) &
                       EVENT_IMPL_MASK;
    if (wr_en && avm_req.address == ADDR_EVENT_MASK) begin
      event_mask_next = avm_req.writedata & EVENT_IMPL_MASK;
    end
    if (wr_en && avm_req.address == ADDR_LINK_CTRL) begin
      link_ctrl_next = avm_req.writedata & (32'h0000_0001 << BIT_CYCLE_ROOT);
    end
    if (overlong_hit) begin
      link_ctrl_next[BIT_CYCLE_ROOT] = 1'b0;
    end
    if (wr_en && avm_req.address == ADDR_HC_CTRL) begin
      hc_ctrl_next = avm_req.writedata & (32'h0000_0001 << BIT_TARDY_ENABLE);
    end
  end

  // ---------------------------------------------------------------------------
  // bus answer: one wait cycle, then ack
  // ---------------------------------------------------------------------------
  always_comb begin
    ack_next   = (avm_req.read | avm_req.write) & ~ack_reg;
    wait_next  = ~ack_next;
    rdata_next = rdata_reg;
    if (rd_en) begin
      unique case (avm_req.address)
        ADDR_EVENT_SET:   rdata_next = event_latch_register;
        ADDR_EVENT_CLEAR: rdata_next = event_latch_register & event_mask_register;
        ADDR_EVENT_MASK:  rdata_next = event_mask_register;
        ADDR_LINK_CTRL:   rdata_next = link_ctrl_reg;
        ADDR_HC_CTRL:     rdata_next = hc_ctrl_reg;
        ADDR_CYCLE_TIMER: rdata_next = cycle_timer;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
    irq_next  = |(event_latch_next & event_mask_next);
    sync_next = sync_pulse;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_latch_register <= EVENT_RESET;
      event_mask_register  <= MASK_RESET;
      link_ctrl_reg        <= LINK_CTRL_RESET;
      hc_ctrl_reg          <= HC_CTRL_RESET;
      rdata_reg            <= 32'h0000_0000;
      ack_reg              <= 1'b0;
      wait_reg             <= 1'b1;
      irq_reg              <= 1'b0;
      sync_reg             <= 1'b0;
      src_q_reg            <= '0;
      hw_prev_reg          <= 32'h0000_0000;
      // follow the live count bit so leaving reset makes no false sync
      cnt_lsb_reg          <= cycle_timer[CNT_LO];
      overlong_run_reg     <= 1'b0;
      overlong_cnt_reg     <= 32'h0000_0000;
      seen_start_reg       <= 1'b1;
      first_gap_reg        <= 1'b1;
    end else begin
      event_latch_register <= event_latch_next;
      event_mask_register  <= event_mask_next;
      link_ctrl_reg        <= link_ctrl_next;
      hc_ctrl_reg          <= hc_ctrl_next;
      rdata_reg            <= rdata_next;
      ack_reg              <= ack_next;
      wait_reg             <= wait_next;
      irq_reg              <= irq_next;
      sync_reg             <= sync_next;
      src_q_reg            <= src;
      hw_prev_reg          <= hw_level;
      cnt_lsb_reg          <= cycle_timer[CNT_LO];
      overlong_run_reg     <= overlong_run_next;
      overlong_cnt_reg     <= overlong_cnt_next;
      seen_start_reg       <= seen_start_next;
      first_gap_reg        <= first_gap_next;
    end
  end

  assign avm_readdata      = rdata_reg;
  assign avm_waitrequest   = wait_reg;
  assign irq               = irq_reg;
  assign cycle_root_enable = link_ctrl_reg[BIT_CYCLE_ROOT];
  assign tardy_ack_enable  = hc_ctrl_reg[BIT_TARDY_ENABLE];
  assign cycle_sync_event  = sync_reg;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_set_edge;
    @(posedge clk) disable iff (srst)
      (hw_rise[BIT_PHY_BYTE] && !event_latch_register[BIT_FATAL_HALT]) |=>
        event_latch_register[BIT_PHY_BYTE];
  endproperty
  a_set_edge: assert property (p_set_edge) else $error("phy byte edge not latched");

  property p_clear_only;
    @(posedge clk) disable iff (srst)
      (event_latch_register[BIT_SOFTWARE] && !wr_clr) |=> event_latch_register[BIT_SOFTWARE];
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("event bit lost without clear");

  property p_read_set;
    @(posedge clk) disable iff (srst)
      (rd_en && avm_req.address == ADDR_EVENT_SET) |=>
        (avm_readdata == $past(event_latch_register)) && !avm_waitrequest;
  endproperty
  a_read_set: assert property (p_read_set) else $error("set port read wrong");

  property p_read_clear;
    @(posedge clk) disable iff (srst)
      (rd_en && avm_req.address == ADDR_EVENT_CLEAR) |=>
        avm_readdata == ($past(event_latch_register) & $past(event_mask_register));
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("clear port read not masked");

  property p_reserved;
    @(posedge clk) disable iff (srst)
      !event_latch_register[BIT_RSVD31] && !event_latch_register[BIT_RSVD28];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved event bit set");

  property p_soft_only;
    @(posedge clk) disable iff (srst)
      (!event_latch_register[BIT_SOFTWARE] && !wr_set) |=> !event_latch_register[BIT_SOFTWARE];
  endproperty
  a_soft_only: assert property (p_soft_only) else $error("software bit set by hardware");

  property p_tardy_gate;
    @(posedge clk) disable iff (srst)
      (!hc_ctrl_reg[BIT_TARDY_ENABLE] && !event_latch_register[BIT_TARDY_ACK] && !wr_set)
        |=> !event_latch_register[BIT_TARDY_ACK];
  endproperty
  a_tardy_gate: assert property (p_tardy_gate) else $error("tardy set while disabled");

  property p_halt_block;
    @(posedge clk) disable iff (srst)
      (event_latch_register[BIT_FATAL_HALT] && !event_latch_register[BIT_TARDY_ACK] && !wr_set)
        |=> !event_latch_register[BIT_TARDY_ACK];
  endproperty
  a_halt_block: assert property (p_halt_block) else $error("tardy set during halt");

  property p_overlong_clears_root;
    @(posedge clk) disable iff (srst)
      overlong_hit |=> !cycle_root_enable ##1 event_latch_register[BIT_OVERLONG];
  endproperty
  a_overlong_clears_root: assert property (p_overlong_clears_root)
    else $error("overlong cycle did not clear root enable");

  property p_sync_toggle;
    @(posedge clk) disable iff (srst)
      $changed(cycle_timer[CNT_LO]) |=> cycle_sync_event;
  endproperty
  a_sync_toggle: assert property (p_sync_toggle) else $error("cycle sync missing");

  property p_irq_level;
    @(posedge clk) disable iff (srst)
      ##1 (irq == |($past(event_latch_next) & $past(event_mask_next)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule : host_interrupt_event_bank

// [verif/host_interrupt_event_bank_tb.sv]
// self-checking testbench for the host interrupt event bank
`timescale 1ns/10ps
module host_interrupt_event_bank_tb;
  import event_bank_pkg::*;
  // ---------------------------------------------------------------------------
  // constants and signals
  // ---------------------------------------------------------------------------
  localparam int          LIMIT  = 20;
  localparam logic [6:0]  T_SEC  = 7'h09;
  localparam logic [12:0] T_CNT  = 13'h0345;
  localparam logic [31:0] TIMER0 = {T_SEC, T_CNT, 12'h000};
  // missed-cycle bit left out: its prediction may fire on gap traffic
  localparam logic [31:0] CARE   = EVENT_IMPL_MASK & ~(32'h1 << BIT_MISSED_CYCLE);
  localparam logic [31:0] ALL    = 32'hffff_ffff;
  typedef struct {
    event_src_t  s;
    logic [31:0] hc;
    logic [31:0] exp;
  } row_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  avmm_req_t   avm_req = '0;
  event_src_t  src = '0;
  logic [31:0] cycle_timer = TIMER0;
  logic [31:0] avm_readdata;
  logic        avm_waitrequest;
  logic        irq;
  logic        cycle_root_enable;
  logic        tardy_ack_enable;
  logic        cycle_sync_event;
  int          failures = 0;
  int          num_checks = 0;
  row_t        rows[9];
  logic [31:0] q;
  int          n;
  host_interrupt_event_bank #(.OVERLONG_LIMIT(LIMIT)) host_interrupt_event_bank_i (
    .clk(clk), .srst(srst), .avm_req(avm_req), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .src(src), .cycle_timer(cycle_timer), .irq(irq),
    .cycle_root_enable(cycle_root_enable), .tardy_ack_enable(tardy_ack_enable),
    .cycle_sync_event(cycle_sync_event));
  initial begin
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task finish_test();
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  // request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avm_req <= '{read: !w, write: w, address: a, writedata: d};
    // only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avm_waitrequest !== 1'b0);
    r = avm_readdata;
    avm_req <= '0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr
  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  task pulse(input event_src_t s);
    src <= s;
    tick(3);
    src <= '0;
    tick(2);
  endtask : pulse
  task toggle_count();
    cycle_timer <= cycle_timer ^ 32'h0000_1000;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (cycle_sync_event === 1'b1) n++;
    end
  endtask : toggle_count
  // ---------------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------------
  initial begin
    rows[0] = '{'{eeprom_done: 1'b1, default: '0}, 32'h0, 32'h1 << BIT_EEPROM_DONE};
    rows[1] = '{'{phy_byte_received: 1'b1, default: '0}, 32'h0, 32'h1 << BIT_PHY_BYTE};
    rows[2] = '{'{context_halt: 1'b1, default: '0}, 32'h0, 32'h1 << BIT_FATAL_HALT};
    rows[3] = '{'{rx_fifo_pending: 1'b1, default: '0}, 32'h0, 32'h0};
    rows[4] = '{'{rx_fifo_pending: 1'b1, default: '0}, 32'h1, 32'h1 << BIT_TARDY_ACK};
    rows[5] = '{'{phy_resp_busy: 1'b1, default: '0}, 32'h1, 32'h1 << BIT_TARDY_ACK};
    rows[6] = '{'{ack_tardy_sent: 1'b1, default: '0}, 32'h1, 32'h1 << BIT_TARDY_ACK};
    rows[7] = '{'{cycle_start_rx: 1'b1, rx_seconds: T_SEC ^ 7'h01, rx_count: T_CNT,
                  default: '0}, 32'h0, 32'h1 << BIT_MISMATCH};
    rows[8] = '{'{cycle_start_rx: 1'b1, rx_seconds: T_SEC, rx_count: T_CNT ^ 13'h0001,
                  default: '0}, 32'h0, 32'h1 << BIT_MISMATCH};
    tick(3);
    check({31'h0, avm_waitrequest}, 32'h1);
    tick(2);
    srst <= 1'b0;
    check({31'h0, irq}, 32'h0);
    rd(ADDR_EVENT_SET);
    check(q, EVENT_RESET);
    check({30'h0, cycle_root_enable, tardy_ack_enable}, 32'h0);
    wr(ADDR_EVENT_MASK, ALL);
    foreach (rows[i]) begin
      wr(ADDR_HC_CTRL, rows[i].hc);
      wr(ADDR_EVENT_CLEAR, ALL);
      check({31'h0, tardy_ack_enable}, {31'h0, rows[i].hc[0]});
      pulse(rows[i].s);
      rd(ADDR_EVENT_SET);
      check(q & CARE, rows[i].exp);
      rd(ADDR_EVENT_CLEAR);
      check(q & CARE, rows[i].exp);
    end
    // write-one set and clear, reserved bits
    wr(ADDR_EVENT_SET, ALL);
    rd(ADDR_EVENT_SET);
    check(q, EVENT_IMPL_MASK);
    wr(ADDR_EVENT_CLEAR, 32'h0);
    wr(ADDR_EVENT_SET, 32'h0);
    rd(ADDR_EVENT_SET);
    check(q, EVENT_IMPL_MASK);
    wr(ADDR_EVENT_CLEAR, 32'h1 << BIT_SOFTWARE);
    rd(ADDR_EVENT_SET);
    check(q, EVENT_IMPL_MASK & ~(32'h1 << BIT_SOFTWARE));
    // unmapped place reads zero and ignores writes
    wr(8'h40, ALL);
    rd(8'h40);
    check(q, 32'h0);
    // mask and interrupt level
    wr(ADDR_EVENT_CLEAR, ALL);
    wr(ADDR_EVENT_MASK, 32'h0);
    wr(ADDR_EVENT_SET, 32'h1 << BIT_SOFTWARE);
    tick(2);
    check({31'h0, irq}, 32'h0);
    rd(ADDR_EVENT_CLEAR);
    check(q, 32'h0);
    wr(ADDR_EVENT_MASK, 32'h1 << BIT_SOFTWARE);
    tick(2);
    check({31'h0, irq}, 32'h1);
    rd(ADDR_EVENT_CLEAR);
    check(q, 32'h1 << BIT_SOFTWARE);
    wr(ADDR_EVENT_CLEAR, 32'h1 << BIT_SOFTWARE);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_EVENT_MASK, ALL);
    // a held source must not set the bit again
    src <= '{eeprom_done: 1'b1, default: '0};
    tick(3);
    wr(ADDR_EVENT_CLEAR, 32'h1 << BIT_EEPROM_DONE);
    tick(4);
    rd(ADDR_EVENT_SET);
    check(q & (32'h1 << BIT_EEPROM_DONE), 32'h0);
    src <= '0;
    // halt blocks the tardy event
    wr(ADDR_HC_CTRL, 32'h1);
    wr(ADDR_EVENT_CLEAR, ALL);
    pulse('{context_halt: 1'b1, default: '0});
    pulse('{rx_fifo_pending: 1'b1, default: '0});
    rd(ADDR_EVENT_SET);
    check(q & CARE, 32'h1 << BIT_FATAL_HALT);
    // overlong cycle: root on/short, root on/long, root off/long
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_LINK_CTRL, (i < 2) ? 32'h1 << BIT_CYCLE_ROOT : 32'h0);
      wr(ADDR_EVENT_CLEAR, ALL);
      pulse('{cycle_start_tx: 1'b1, default: '0});
      tick((i == 0) ? 0 : 2 * LIMIT);
      pulse('{subaction_gap_end: 1'b1, default: '0});
      rd(ADDR_EVENT_SET);
      check(q & (32'h1 << BIT_OVERLONG), (i == 1) ? 32'h1 << BIT_OVERLONG : 32'h0);
      check({31'h0, cycle_root_enable}, (i == 0) ? 32'h1 : 32'h0);
    end
    // cycle sync and missed cycle
    wr(ADDR_EVENT_CLEAR, ALL);
    toggle_count();
    check(n, 1);
    toggle_count();
    check(n, 1);
    rd(ADDR_EVENT_SET);
    check(q & (32'h1 << BIT_MISSED_CYCLE), 32'h1 << BIT_MISSED_CYCLE);
    wr(ADDR_EVENT_CLEAR, ALL);
    pulse('{cycle_start_rx: 1'b1, rx_seconds: T_SEC, rx_count: T_CNT, default: '0});
    toggle_count();
    rd(ADDR_EVENT_SET);
    check(q & 32'h00c0_0000, 32'h0);
    // arbitration reset gap with no start since the sync predicts a loss
    wr(ADDR_EVENT_CLEAR, ALL);
    pulse('{arb_reset_gap: 1'b1, default: '0});
    rd(ADDR_EVENT_SET);
    check(q & (32'h1 << BIT_MISSED_CYCLE), 32'h1 << BIT_MISSED_CYCLE);
    // mid-run reset brings every register back
    wr(ADDR_EVENT_SET, ALL);
    rd(ADDR_CYCLE_TIMER);
    check(q, cycle_timer);
    check({31'h0, irq}, 32'h1);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    check({31'h0, irq}, 32'h0);
    rd(ADDR_EVENT_SET);
    check(q, EVENT_RESET);
    rd(ADDR_EVENT_MASK);
    check(q, MASK_RESET);
    check({30'h0, cycle_root_enable, tardy_ack_enable}, 32'h0);
    finish_test();
  end
  // cut a hang short well past the expected run length
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule : host_interrupt_event_bank_tb
